// ===== src/its_pkg.sv
// Purpose: shared constants and types of the i2c transaction sequencer
// Assumes: 50 MHz system clock
// Notes:   fast-mode divider derived from named rates; DIV_MIN floor is fixed
`default_nettype none
package its_pkg;
   // ************************************************
   // clock, bit-rate and framing figures
   // ************************************************
   localparam int CLK_HZ         = 50_000_000;
   localparam int FAST_MODE_BPS  = 400_000;
   localparam logic [15:0] DIV_FAST = 16'((CLK_HZ / (4 * FAST_MODE_BPS)) + 1);
   localparam logic [15:0] DIV_MIN  = 16'h0002;
   localparam logic [3:0]  BIT_LAST = 4'h7;
   localparam logic [3:0]  BIT_ACK  = 4'h8;
   localparam logic        DIR_WRITE = 1'b0;
   localparam logic        DIR_READ  = 1'b1;
   localparam logic [1:0]  PH_MAX   = 2'h3;

   // ************************************************
   // enumerations and carriers
   // ************************************************
   typedef enum logic [1:0] {
      ITS_KIND_WRITE = 2'b00,
      ITS_KIND_READ  = 2'b01,
      ITS_KIND_WRRD  = 2'b10
   } its_kind_e;

   typedef enum logic [3:0] {
      ITS_IDLE   = 4'h0,
      ITS_START  = 4'h1,
      ITS_SHIFT  = 4'h2,
      ITS_ACK    = 4'h3,
      ITS_STOP   = 4'h4,
      ITS_RSTART = 4'h5,
      ITS_HOLD   = 4'h6,
      ITS_SL_ADR = 4'h7,
      ITS_SL_ACK = 4'h8,
      ITS_SL_DAT = 4'h9,
      ITS_SL_DAK = 4'hA
   } its_state_e;

   typedef struct packed {
      its_kind_e  kind;
      logic [6:0] addr;
      logic [7:0] wrCount;
      logic [7:0] rdCount;
      logic       noStop;
   } its_cmd_s;

   typedef struct packed {
      logic       isRead;
      logic       nack;
      logic [7:0] data;
   } its_word_s;

   // line pins: output enables only (oe high = pull low)
   typedef struct packed {
      logic sclOe;
      logic sdaOe;
   } its_pins_s;
endpackage : its_pkg
`default_nettype wire

// ===== src/its_sequencer.sv
// Purpose: i2c master/slave transaction sequencer
// Assumes: pins open-drain outside; inputs synchronous to clk
// Notes:   one state struct, one always_comb, one always_ff
//
// How it works
// R01: master or slave, chosen per instance input
// R02: master drives both clock and data
// R03: clock from divided system clock, settable
// R04: divider default gives fast-mode rate
// R05: start only while bus idle
// R06: watch lines to track bus busy
// R07: seven address bits then direction bit
// R08: slave acknowledges its own address with write direction only
// R09: next write byte only after acknowledge
// R10: nack aborts write, master stops sending
// R11: reading master acknowledges each byte before the final one
// R12: master nacks the final wanted byte
// R13: normal end is a stop condition
// R14: skipped stop means repeated start next
// R15: combined write then read, no stop
// R16: repeated start and new address between phases
// R17: software picks offset in write phase
// R18: direction low write; ack is data low
// R19: open-drain drive, levels read back
`default_nettype none
module its_sequencer
   import its_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic            slaveMode,
   input  wire logic [6:0]      ownAddr,
   input  wire logic [15:0]     clkDiv,
   input  wire its_pkg::its_cmd_s cmd,
   input  wire logic            cmdValid,
   output var  logic            cmdReady,
   input  wire logic [7:0]      txData,
   input  wire logic            txValid,
   output var  logic            txReady,
   output var  its_pkg::its_word_s rxWord,
   output var  logic            rxValid,
   input  wire logic            rxReady,
   output var  logic            busBusy,
   output var  logic            aborted,
   input  wire logic            sclIn,
   output var  logic            sclOut,
   output var  logic            sclOe,
   input  wire logic            sdaIn,
   output var  logic            sdaOut,
   output var  logic            sdaOe
);
   import its_pkg::*;

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      its_state_e st;
      its_cmd_s   cur;
      logic [15:0] div;
      logic [1:0] ph;
      logic [3:0] bitN;
      logic [7:0] sh;
      logic       addrPh;
      logic       rdPh;
      logic [7:0] left;
      logic       busy;
      logic       sclQ;
      logic       sdaQ;
      logic       held;
      its_pins_s  pins;
      logic       cmdRdy;
      logic       txRdy;
      logic       abrt;
      its_word_s  b0;
      its_word_s  b1;
      logic [1:0] cnt;
      logic       rxV;
   } its_state_s;

   its_state_s s;
   its_state_s next_s;

   // two-entry buffer push candidates
   its_word_s pushWord;
   logic      push;
   logic      pop;

   function automatic logic tick(input logic [15:0] d, input logic [15:0] lim);
      tick = (d >= 16'(lim - 16'h0001));  // lim clocks per quarter bit
   endfunction

   // ************************************************
   // next-state logic
   // ************************************************
   always_comb begin
      logic [15:0] lim;
      logic        sclRise;
      logic        sclFall;
      lim = (clkDiv < DIV_MIN) ? DIV_MIN : clkDiv;  // see R03 R04
      sclRise = sclIn & ~s.sclQ;
      sclFall = ~sclIn & s.sclQ;
      next_s = s;
      push = 1'b0;
      pushWord = '0;
      pop = rxValid & rxReady;
      next_s.sclQ = sclIn;
      next_s.sdaQ = sdaIn;
      next_s.txRdy = 1'b0;
      next_s.cmdRdy = 1'b0;
      // start/stop seen on the wire keep the busy flag honest
      if (sclIn && s.sdaQ && !sdaIn) begin
         next_s.busy = 1'b1;  // see R06
      end else if (sclIn && !s.sdaQ && sdaIn) begin
         next_s.busy = 1'b0;  // see R06
      end
      next_s.div = tick(s.div, lim) ? 16'h0000 : 16'(s.div + 16'h0001);
      case (s.st)
         ITS_IDLE: begin
            next_s.pins = '0;
            next_s.ph = '0;
            if (slaveMode) begin  // see R01
               if (sclIn && s.sdaQ && !sdaIn) begin
                  next_s.st = ITS_SL_ADR;
                  next_s.bitN = '0;
               end
            end else if (cmdValid && (!s.busy || s.held) && sclIn && sdaIn) begin  // see R05
               next_s.cmdRdy = 1'b1;
               next_s.cur = cmd;
               next_s.rdPh = (cmd.kind == ITS_KIND_READ);
               next_s.st = s.held ? ITS_RSTART : ITS_START;  // see R14
               next_s.div = '0;
            end
         end
         ITS_START, ITS_RSTART: if (tick(s.div, lim)) begin
            next_s.ph = 2'(s.ph + 2'h1);
            // rstart: release data, raise clock, then pull data low while clock high
            if (s.st == ITS_RSTART && s.ph == 2'h0) next_s.pins = '{sclOe: 1'b1, sdaOe: 1'b0};
            if (s.st == ITS_RSTART && s.ph == 2'h1) next_s.pins.sclOe = 1'b0;
            if (s.ph == 2'h2) next_s.pins.sdaOe = 1'b1;  // see R02
            if (s.ph == PH_MAX) begin
               next_s.pins.sclOe = 1'b1;
               next_s.busy = 1'b1;
               next_s.held = 1'b0;
               next_s.st = ITS_SHIFT;
               next_s.addrPh = 1'b1;
               next_s.bitN = '0;
               next_s.sh = {s.cur.addr, s.rdPh ? DIR_READ : DIR_WRITE};  // see R07 R18
               next_s.left = s.rdPh ? s.cur.rdCount : s.cur.wrCount;
               next_s.ph = '0;
            end
         end
         ITS_SHIFT, ITS_ACK: if (tick(s.div, lim)) begin
            next_s.ph = 2'(s.ph + 2'h1);
            if (s.ph == 2'h0) begin
               // clock low: put bit on data line (or release for receive)
               if (s.st == ITS_SHIFT)
                  next_s.pins.sdaOe = (s.addrPh || !s.rdPh) ? ~s.sh[7] : 1'b0;
               else
                  next_s.pins.sdaOe = (!s.addrPh && s.rdPh) ? (s.left != 8'h01) : 1'b0;  // see R11 R12
            end else if (s.ph == 2'h1) begin
               next_s.pins.sclOe = 1'b0;
            end else if (s.ph == 2'h2) begin
               if (sclIn) begin  // clock stretching: wait for released line
                  if (s.st == ITS_SHIFT) next_s.sh = {s.sh[6:0], sdaIn};  // see R19
               end else begin
                  next_s.ph = s.ph;
               end
            end else if (s.st == ITS_SHIFT && s.bitN == BIT_LAST && !s.addrPh && s.rdPh
                         && s.cnt == 2'h2 && !pop) begin
               // buffer full: hold clock high until a word drains, no byte lost
               next_s.ph = s.ph;
            end else begin
               next_s.pins.sclOe = 1'b1;
               next_s.ph = '0;
               next_s.bitN = 4'(s.bitN + 4'h1);
               if (s.st == ITS_SHIFT && s.bitN == BIT_LAST) begin
                  next_s.st = ITS_ACK;
                  if (!s.addrPh && s.rdPh) begin
                     push = 1'b1;
                     pushWord = '{isRead: 1'b1, nack: 1'b0, data: s.sh};
                  end
               end else if (s.st == ITS_ACK) begin
                  next_s.bitN = '0;
                  next_s.st = ITS_SHIFT;
                  next_s.addrPh = 1'b0;
                  if ((s.addrPh || !s.rdPh) && s.sdaQ) begin  // see R10 R18
                     next_s.abrt = 1'b1;
                     next_s.st = ITS_STOP;
                  end else if (!s.addrPh && s.rdPh) begin
                     next_s.left = 8'(s.left - 8'h01);
                  end else if (!s.addrPh) begin
                     // written bytes are not echoed into the receive buffer
                     next_s.left = 8'(s.left - 8'h01);
                  end
                  if (next_s.st == ITS_SHIFT && next_s.left == 8'h00) begin
                     if (s.cur.kind == ITS_KIND_WRRD && !s.rdPh) begin
                        next_s.rdPh = 1'b1;
                        next_s.st = ITS_RSTART;  // see R15 R16
                     end else begin
                        next_s.st = s.cur.noStop ? ITS_HOLD : ITS_STOP;  // see R13 R14
                     end
                  end else if (next_s.st == ITS_SHIFT && !s.rdPh) begin
                     next_s.st = ITS_HOLD;  // wait for next write byte  see R09
                  end
               end
            end
         end
         ITS_HOLD: begin
            // clock held low; either fetch byte or park for repeated start
            if (s.left != 8'h00 && !s.rdPh && !s.abrt) begin
               if (txValid) begin
                  next_s.txRdy = 1'b1;
                  next_s.sh = txData;
                  next_s.st = ITS_SHIFT;
               end
            end else begin
               next_s.held = 1'b1;
               next_s.st = ITS_IDLE;
               next_s.pins = '{sclOe: 1'b1, sdaOe: 1'b0};
            end
         end
         ITS_STOP: if (tick(s.div, lim)) begin
            next_s.ph = 2'(s.ph + 2'h1);
            if (s.ph == 2'h0) next_s.pins.sdaOe = 1'b1;
            if (s.ph == 2'h1) next_s.pins.sclOe = 1'b0;
            if (s.ph == PH_MAX) begin
               next_s.pins.sdaOe = 1'b0;
               next_s.st = ITS_IDLE;
               next_s.held = 1'b0;
            end
         end
         ITS_SL_ADR, ITS_SL_DAT: begin
            if (sclRise) begin
               next_s.sh = {s.sh[6:0], sdaIn};
               next_s.bitN = 4'(s.bitN + 4'h1);
            end
            if (sclFall && s.bitN == BIT_ACK) begin
               next_s.bitN = '0;
               if (s.st == ITS_SL_DAT) begin
                  next_s.pins.sdaOe = rxReady | ~rxValid;
                  push = rxReady | ~rxValid;  // nacked byte dropped, stored words kept
                  pushWord = '{isRead: 1'b0, nack: 1'b0, data: s.sh};
                  next_s.st = ITS_SL_DAK;
               end else if (s.sh[7:1] == ownAddr && s.sh[0] == DIR_WRITE) begin
                  next_s.pins.sdaOe = 1'b1;  // see R08
                  next_s.st = ITS_SL_ACK;
               end else begin
                  next_s.st = ITS_IDLE;
               end
            end
            if (sclIn && s.sdaQ && !sdaIn && s.st == ITS_SL_DAT) begin
               next_s.st = ITS_SL_ADR;
               next_s.bitN = '0;
            end
            if (sclIn && !s.sdaQ && sdaIn) next_s.st = ITS_IDLE;
         end
         ITS_SL_ACK, ITS_SL_DAK: if (sclFall) begin
            next_s.pins.sdaOe = 1'b0;
            next_s.st = ITS_SL_DAT;
         end
         default: next_s.st = ITS_IDLE;
      endcase
      if (cmdValid && s.st == ITS_IDLE && !slaveMode) next_s.abrt = 1'b0;
      // two-entry buffer: count update; master read stalls when full, slave nacks unless empty or rxReady
      if (push && !(pop && s.cnt != 2'h0)) begin
         if (s.cnt == 2'h0) next_s.b0 = pushWord;
         else next_s.b1 = pushWord;
         next_s.cnt = (s.cnt == 2'h2) ? s.cnt : 2'(s.cnt + 2'h1);
      end else if (pop && push) begin
         next_s.b0 = (s.cnt == 2'h2) ? s.b1 : pushWord;
         if (s.cnt == 2'h2) next_s.b1 = pushWord;
      end else if (pop) begin
         next_s.b0 = s.b1;
         next_s.cnt = 2'(s.cnt - 2'h1);
      end
      next_s.rxV = (next_s.cnt != 2'h0);
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
         s.sclQ <= 1'b1;
         s.sdaQ <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from state flops; open drain drives only low
   assign sclOe    = s.pins.sclOe;  // see R19
   assign sdaOe    = s.pins.sdaOe;  // see R19
   assign sclOut   = 1'b0;
   assign sdaOut   = 1'b0;
   assign busBusy  = s.busy;
   assign aborted  = s.abrt;
   assign cmdReady = s.cmdRdy;
   assign txReady  = s.txRdy;
   assign rxWord   = s.b0;
   assign rxValid  = s.rxV;

   // ************************************************
   // checks
   // ************************************************
   property p_start_idle;
      @(posedge clk) disable iff (sys_rst)
      (s.st == ITS_IDLE && next_s.st == ITS_START) |-> !s.busy;
   endproperty
   a_start_idle: assert property (p_start_idle) else $error("start on busy bus");  // see R05

   property p_nack_stop;
      @(posedge clk) disable iff (sys_rst)
      $rose(s.abrt) |-> s.st == ITS_STOP;
   endproperty
   a_nack_stop: assert property (p_nack_stop) else $error("nack did not lead to stop");  // see R10

   property p_buf_bound;
      @(posedge clk) disable iff (sys_rst)
      s.cnt <= 2'h2;
   endproperty
   a_buf_bound: assert property (p_buf_bound) else $error("buffer overfilled");

   // a full buffer must never take a word it cannot keep
   property p_no_overrun;
      @(posedge clk) disable iff (sys_rst)
      push |-> !(s.cnt == 2'h2 && !pop);
   endproperty
   a_no_overrun: assert property (p_no_overrun) else $error("buffer overrun");  // see R11

   // last wanted byte leaves the data line released
   property p_last_nack;
      @(posedge clk) disable iff (sys_rst)
      (s.st == ITS_ACK && !s.addrPh && s.rdPh && s.left == 8'h01 && s.ph == 2'h2) |-> !s.pins.sdaOe;
   endproperty
   a_last_nack: assert property (p_last_nack) else $error("final read byte acknowledged");  // see R12

   // repeated start: data low while clock released
   property p_rstart_shape;
      @(posedge clk) disable iff (sys_rst)
      (s.st == ITS_RSTART && s.ph == PH_MAX) |-> (s.pins.sdaOe && !s.pins.sclOe);
   endproperty
   a_rstart_shape: assert property (p_rstart_shape) else $error("repeated start malformed");  // see R16
endmodule : its_sequencer
`default_nettype wire

// ===== testbench/its_slave_model.sv
// Purpose: behavioural far-side target on the shared two-wire bus
// Assumes: lines are pulled up, so release reads high
// Notes:   logs address phases, written bytes and master acks
`default_nettype none
module its_slave_model #(
   parameter logic [6:0] ADDR    = 7'h31,
   parameter logic [7:0] RD_BASE = 8'hC3
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] nackAt,
   output var  logic       sdaOe
);
   timeunit 1ns;
   timeprecision 1ps;
   int         cnt = 0;
   int         idx = 0;
   int         nStart = 0;
   int         nStop = 0;
   logic       inAddr = 0;
   logic       sel = 0;
   logic       rd = 0;
   logic       mAck = 0;
   logic [7:0] sh = 8'h00;
   logic [7:0] outB = 8'h00;
   logic       dirQ[$];
   logic [7:0] wrQ[$];
   logic       ackQ[$];
   initial sdaOe = 1'b0;
   // start or repeated start restarts the frame
   always @(negedge sda) if (scl === 1'b1) begin
      nStart++;
      cnt = 0;
      inAddr = 1'b1;
      sel = 1'b0;
   end
   // stop frees the target
   always @(posedge sda) if (scl === 1'b1) begin
      nStop++;
      sel = 1'b0;
   end
   // bits are taken msb first on the rising clock
   always @(posedge scl) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (sel && rd && !inAddr) begin
         mAck = ~sda;
         ackQ.push_back(mAck);
      end
      cnt++;
   end
   // line changes only while the clock is low, never framing by accident
   always @(negedge scl) begin
      if (cnt == 8) begin
         if (inAddr) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
            idx = 0;
            if (sel) dirQ.push_back(sh[0]);
            sdaOe = sel;
         end else if (sel && !rd) begin
            wrQ.push_back(sh);
            sdaOe = (idx != int'(nackAt));
            idx++;
         end else sdaOe = 1'b0;
      end else if (cnt == 9) begin
         cnt = 0;
         sdaOe = 1'b0;
         if (sel && rd && (inAddr || mAck)) begin
            outB = RD_BASE + 8'(idx);
            idx++;
            sdaOe = ~outB[7];
         end
         inAddr = 1'b0;
      end else if (sel && rd && !inAddr && cnt > 0 && cnt < 8) sdaOe = ~outB[7-cnt];
   end
endmodule // its_slave_model
`default_nettype wire

// ===== testbench/tb.sv
// Purpose: self-checking bench of the transaction sequencer
// Assumes: one far-side target model, bench acts as a second master
// Notes:   fast-mode divider throughout
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import its_pkg::*;
   localparam logic [6:0] SADR = 7'h31;
   localparam logic [7:0] RDB  = 8'hC3;
   logic       clk = 0, sys_rst = 1, slaveMode = 0, cmdValid = 0, txValid = 0, rxReady = 1;
   logic       tbScl = 0, tbSda = 0, prevScl = 1, mOe;
   logic [6:0] ownAddr = 7'h2A;
   logic [15:0] clkDiv = DIV_FAST;
   logic [7:0] txData = 0, nackAt = 8'hFF;
   logic [7:0] txB[8];
   its_cmd_s   cmd = '0;
   its_word_s  rxWord;
   its_word_s  rxQ[$];
   logic       cmdReady, txReady, rxValid, busBusy, aborted, sclOut, sclOe, sdaOut, sdaOe;
   int         txIdx = 0, txN = 0, n_fail = 0, total_checks = 0, cyc = 0, per = 0, lastUp = 0, s0, p0;
   wire        sclLine = ~(sclOe | tbScl);
   wire        sdaLine = ~(sdaOe | mOe | tbSda);
   its_sequencer uut (.clk(clk), .sys_rst(sys_rst), .slaveMode(slaveMode), .ownAddr(ownAddr),
      .clkDiv(clkDiv), .cmd(cmd), .cmdValid(cmdValid), .cmdReady(cmdReady), .txData(txData),
      .txValid(txValid), .txReady(txReady), .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady),
      .busBusy(busBusy), .aborted(aborted), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
   its_slave_model #(.ADDR(SADR), .RD_BASE(RDB)) sm (.scl(sclLine), .sda(sdaLine), .nackAt(nackAt), .sdaOe(mOe));
   // ************************************************
   // clock, feeders and watchdog
   // ************************************************
   initial forever #10 clk = ~clk;
   // bit period, tx feed and rx capture, all sampled before the edge lands
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (sclLine === 1'b1 && prevScl === 1'b0) begin
         if (lastUp != 0 && per == 0) per = cyc - lastUp;
         lastUp = cyc;
      end
      prevScl = sclLine;
      if (txReady === 1'b1) txIdx = txIdx + 1;
      txValid <= (txIdx < txN);
      txData <= txB[txIdx[2:0]];
      if (rxValid === 1'b1 && rxReady === 1'b1) rxQ.push_back(rxWord);
      if (cyc == 90000) begin
         n_fail++;
         conclude();
      end
   end
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic conclude();
      if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic clr();
      s0 = sm.nStart;
      p0 = sm.nStop;
      sm.wrQ.delete();
      sm.dirQ.delete();
      sm.ackQ.delete();
      rxQ.delete();
      per = 0;
      lastUp = 0;
      txIdx = 0;
   endtask
   task automatic runCmd(input its_kind_e k, input logic [6:0] a, input logic [7:0] w, r, input logic ns);
      int i;
      @(posedge clk);
      cmd <= '{k, a, w, r, ns};
      cmdValid <= 1'b1;
      for (i = 0; i < 4000 && cmdReady !== 1'b1; i++) @(negedge clk);
      chk(cmdReady, 1);
      @(posedge clk);
      cmdValid <= 1'b0;
   endtask
   task automatic waitFree();
      int i;
      for (i = 0; i < 400 && busBusy !== 1'b1; i++) @(negedge clk);
      for (i = 0; i < 20000 && busBusy !== 1'b0; i++) @(negedge clk);
      chk(busBusy, 0);
   endtask
   task automatic qd();
      repeat (clkDiv) @(posedge clk);
   endtask
   // bench as bus master: one bit, sampled mid-high
   task automatic mBit(input logic b, output logic s);
      tbSda <= ~b;
      qd();
      tbScl <= 1'b0;
      qd();
      @(negedge clk);
      s = sdaLine;
      qd();
      tbScl <= 1'b1;
      qd();
   endtask
   task automatic mByte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) mBit(v[i], s);
      mBit(1'b1, s);
      ack = ~s;
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   task automatic tWrite();
      clr();
      txB[0] = 8'h5A;
      txB[1] = 8'hA5;
      txN = 2;
      runCmd(ITS_KIND_WRITE, SADR, 8'h02, 8'h00, 1'b0);
      waitFree();
      chk(sm.wrQ.size(), 2);
      chk({sm.wrQ[0], sm.wrQ[1]}, 16'h5AA5);
      chk(sm.dirQ[0], DIR_WRITE);
      chk(sm.nStart - s0, 1);
      chk(sm.nStop - p0, 1);
      chk(per, 4 * DIV_FAST);
      chk({sclOut, sdaOut}, 0);
   endtask
   task automatic tReadChain();
      clr();
      runCmd(ITS_KIND_READ, SADR, 8'h00, 8'h03, 1'b1);
      for (int i = 0; i < 20000 && rxQ.size() < 3; i++) @(negedge clk);
      txB[0] = 8'h11;
      txN = 1;
      runCmd(ITS_KIND_WRITE, SADR, 8'h01, 8'h00, 1'b0);
      waitFree();
      for (int i = 0; i < 3; i++) chk(rxQ[i].data, 16'(RDB + i));
      chk({sm.ackQ[0], sm.ackQ[1], sm.ackQ[2]}, 3'b110);
      chk({sm.dirQ[0], sm.dirQ[1]}, 2'b10);
      chk(sm.nStart - s0, 2);
      chk(sm.nStop - p0, 1);
   endtask
   task automatic tCombined();
      clr();
      @(posedge clk);
      rxReady <= 1'b0;
      txB[0] = 8'h07;
      txN = 1;
      runCmd(ITS_KIND_WRRD, SADR, 8'h01, 8'h02, 1'b0);
      waitFree();
      chk(sm.wrQ[0], 8'h07);
      chk({sm.dirQ[0], sm.dirQ[1]}, 2'b01);
      chk(sm.nStart - s0, 2);
      chk(sm.nStop - p0, 1);
      chk(rxValid, 1);
      @(posedge clk);
      rxReady <= 1'b1;
      repeat (6) @(negedge clk);
      chk(rxQ.size(), 2);
      chk({rxQ[0].data, rxQ[1].data}, {RDB, 8'(RDB + 1)});
   endtask
   task automatic tAbort();
      clr();
      @(posedge clk);
      nackAt <= 8'h01;
      for (int i = 0; i < 3; i++) txB[i] = 8'h20 + 8'(i);
      txN = 3;
      runCmd(ITS_KIND_WRITE, SADR, 8'h03, 8'h00, 1'b0);
      waitFree();
      chk(sm.wrQ.size(), 2);
      chk(aborted, 1);
      chk(sm.nStop - p0, 1);
      clr();
      nackAt <= 8'hFF;
      txN = 0;
      runCmd(ITS_KIND_WRITE, 7'h55, 8'h00, 8'h00, 1'b0);
      waitFree();
      chk(aborted, 1);
      chk(sm.dirQ.size(), 0);
   endtask
   task automatic tBusy();
      int hits;
      hits = 0;
      clr();
      @(posedge clk);
      tbSda <= 1'b1;
      cmd <= '{ITS_KIND_WRITE, SADR, 8'h00, 8'h00, 1'b0};
      cmdValid <= 1'b1;
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         if (cmdReady === 1'b1) hits++;
      end
      chk(hits, 0);
      chk(busBusy, 1);
      @(posedge clk);
      tbSda <= 1'b0;
      for (int i = 0; i < 4000 && cmdReady !== 1'b1; i++) @(negedge clk);
      chk(cmdReady, 1);
      @(posedge clk);
      cmdValid <= 1'b0;
      waitFree();
   endtask
   task automatic tSlave();
      logic a;
      clr();
      @(posedge clk);
      slaveMode <= 1'b1;
      tbSda <= 1'b1;
      qd();
      tbScl <= 1'b1;
      qd();
      mByte({ownAddr, DIR_WRITE}, a);
      chk(a, 1);
      mByte(8'h96, a);
      chk(a, 1);
      tbSda <= 1'b1;
      qd();
      tbScl <= 1'b0;
      qd();
      tbSda <= 1'b0;
      repeat (8) @(negedge clk);
      chk(rxQ.size(), 1);
      chk({rxQ[0].isRead, rxQ[0].data}, 9'h096);
   endtask
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      tWrite();
      tReadChain();
      tCombined();
      tAbort();
      tBusy();
      tSlave();
      conclude();
   end
endmodule // tb
`default_nettype wire
